// ### hw/cpf_frontend.sv
// Purpose: Command ring front end: ring store, fetch, list copy, font lookup
// Assumes: Register port strobes are one cycle and never both at once
// Notes: Engine takes two clocks per ring word
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Ring of 4 Kbyte; host fills it, engine runs entries strictly in order.
// - Host moves write pointer; read pointer moves only after a command finishes.
// - Equal pointers mean ring empty and every command done without error.
// - Ring writes past offset 4095 wrap to offset 0.
// - Entries are 4-byte words; an unaligned write pointer is an error.
// - Pad bytes after variable data are skipped to the next word boundary.
// - Bulk space register reports free space; bulk port writes the ring and moves the pointer.
// - Each list word goes to list_write_offset, which then increments.
// - new_list_command clears list_write_offset.
// - Plain list words in the ring are copied unchanged to the list.
// - Finishing the last queued command raises queue_drained_irq.
// - Fonts chosen by handles 0 to 31, glyphs 0 to 127.
// - Metrics block is 148 bytes: widths, then five words.
// - Built-in metrics table base comes from a fixed ROM pointer.
// - Built-in font n block lies at base plus 148 times (n minus 16).
// - Fonts 16 to 34; 16 to 31 on handles by default, rest via assign.
// - Fonts 17 and 19 index codes 0x80 to 0xFF; other built-ins 0x20 to 0x7E, custom 0x00 to 0x7F.
// - Custom metrics addresses come from bind_custom_glyphset commands.
// - Corner radius is font height times 3 divided by 16.
// - On fault: read pointer 0xFFF, raise queue_drained_irq, stop.
module cpf_frontend (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [12:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata_r,
	output logic dl_we_r,
	output logic [10:0] dl_addr_r,
	output logic [31:0] dl_data_r,
	output logic queue_drained_irq_r
);
	// ==========================================================
	// State
	logic [31:0] ring_mem [0:cpf_pkg::RING_WORDS-1];
	logic [31:0] ring_q_r;
	logic [11:0] wr_ptr_r;
	logic [11:0] rd_ptr_r;
	logic [11:0] fetch_ptr_r;
	cpf_pkg::cpf_state_t state_r;
	cpf_pkg::cpf_op_t op_r;
	logic [1:0] args_left_r;
	logic [31:0] arg0_r;
	logic [29:0] skip_r;
	logic [11:0] dl_cnt_r;
	logic hold_r;
	logic [5:0] font_num_r [0:cpf_pkg::HANDLES-1];
	logic font_ok_r [0:cpf_pkg::HANDLES-1];
	logic cust_r [0:cpf_pkg::HANDLES-1];
	logic [31:0] cust_addr_r [0:cpf_pkg::HANDLES-1];
	logic [4:0] q_handle_r;
	logic [7:0] q_code_r;
	logic [15:0] height_r;

	// Wrapping pointer step, used by fetch and bulk port
	function automatic logic [11:0] ptr_inc(input logic [11:0] p);
		ptr_inc = p + cpf_pkg::PTR_STEP;
	endfunction

	// ==========================================================
	// Register port decode
	wire in_ring = addr < cpf_pkg::A_RING_TOP;
	wire wr_ring = wr && in_ring;
	wire wr_wptr = wr && addr == cpf_pkg::A_WR_PTR;
	wire wr_rptr = wr && addr == cpf_pkg::A_RD_PTR;
	wire wr_bulk = wr && addr == cpf_pkg::A_BULK_WR;
	wire wr_hold = wr && addr == cpf_pkg::A_HOLD;
	wire wr_query = wr && addr == cpf_pkg::A_GLYPH_Q;
	wire wr_height = wr && addr == cpf_pkg::A_RADIUS;
	wire bad_wptr = wr_wptr && wdata[1:0] != 2'h0;
	wire ring_we = wr_ring || wr_bulk;
	// Window writes land on their own word, bulk writes at the write pointer
	wire [9:0] ring_widx = wr_bulk ? wr_ptr_r[11:2] : addr[11:2];

	// ==========================================================
	// Engine decode of the fetched word
	wire [31:0] w = ring_q_r;
	wire exec = state_r == cpf_pkg::ST_EXEC && !hold_r && !bad_wptr;
	wire in_skip = skip_r != 30'h0;
	wire in_args = args_left_r != 2'h0;
	wire is_head = exec && !in_skip && !in_args;
	wire is_co = w[31:24] == cpf_pkg::OP_COPROC;
	wire dl_full = dl_cnt_r[cpf_pkg::DL_W];
	wire copy_go = is_head && !is_co && !dl_full;
	wire new_list_go = is_head && is_co && w[23:0] == cpf_pkg::OP_NEW_LIST;
	wire op_assign = w[23:0] == cpf_pkg::OP_ASSIGN_BI;
	wire op_bind = w[23:0] == cpf_pkg::OP_BIND_CUST;
	wire op_inline = w[23:0] == cpf_pkg::OP_INLINE;
	wire op_known = op_assign || op_bind || op_inline || w[23:0] == cpf_pkg::OP_NEW_LIST;
	wire last_arg = exec && !in_skip && args_left_r == 2'h1;
	wire font_arg_ok = w[31:6] == 26'h0 && w[5:0] >= cpf_pkg::FONT_FIRST
		&& w[5:0] <= cpf_pkg::FONT_LAST;
	// Variable data rounded up to whole words
	wire [29:0] skip_len = w[31:2] + {29'h0, w[1:0] != 2'h0};
	wire bad_cmd = (is_head && is_co && !op_known) || (is_head && !is_co && dl_full)
		|| (last_arg && op_r == cpf_pkg::OPK_ASSIGN && !font_arg_ok);
	wire fault_go = (bad_cmd || bad_wptr) && state_r != cpf_pkg::ST_FAULT && !hold_r;
	wire cmd_done = exec && !bad_cmd && (copy_go || new_list_go || skip_r == 30'h1
		|| (last_arg && (op_r != cpf_pkg::OPK_INLINE || skip_len == 30'h0)));
	wire [11:0] fetch_nxt = ptr_inc(fetch_ptr_r);
	wire drain_go = cmd_done && fetch_nxt == wr_ptr_r;
	wire [4:0] arg_h = arg0_r[4:0];

	// ==========================================================
	// Font lookup for the queried handle and character code
	wire [5:0] q_font = font_num_r[q_handle_r];
	wire q_cust = cust_r[q_handle_r];
	wire [5:0] q_rel = q_font - cpf_pkg::FONT_FIRST;
	wire [31:0] q_bi_addr = cpf_pkg::BUILTIN_BASE
		+ cpf_pkg::METRICS_BYTES * {26'h0, q_rel};
	wire [31:0] q_metrics = q_cust ? cust_addr_r[q_handle_r] : q_bi_addr;
	wire q_hi = !q_cust && (q_font == cpf_pkg::FONT_HI_A || q_font == cpf_pkg::FONT_HI_B);
	wire [7:0] q_idx = q_hi ? q_code_r - cpf_pkg::CHAR_SHIFT : q_code_r;
	wire q_in_range = q_cust ? !q_code_r[7] : q_hi ? q_code_r[7]
		: (q_code_r >= cpf_pkg::CHAR_LO && q_code_r <= cpf_pkg::CHAR_HI);
	wire q_valid = font_ok_r[q_handle_r] && q_in_range;
	// Width byte of the glyph sits in the first 128 bytes of the block
	wire [31:0] q_width_addr = q_metrics + {25'h0, q_idx[6:0]};
	wire [17:0] height3 = {2'h0, height_r} * {16'h0, cpf_pkg::RADIUS_MUL};
	wire [17:0] radius = height3 >> cpf_pkg::RADIUS_SHIFT;

	// ==========================================================
	// Status and read mux
	wire [11:0] fullness = wr_ptr_r - rd_ptr_r;
	wire [11:0] free_space = state_r == cpf_pkg::ST_FAULT ? 12'h000
		: cpf_pkg::RING_USABLE - fullness;
	wire idle = state_r == cpf_pkg::ST_IDLE && rd_ptr_r == wr_ptr_r;
	wire [31:0] status = {28'h0, q_valid, hold_r, state_r == cpf_pkg::ST_FAULT, idle};
	wire [31:0] rd_mux =
		addr == cpf_pkg::A_RD_PTR ? {20'h0, rd_ptr_r} :
		addr == cpf_pkg::A_WR_PTR ? {20'h0, wr_ptr_r} :
		addr == cpf_pkg::A_LIST_OFS ? {18'h0, dl_cnt_r, 2'h0} :
		addr == cpf_pkg::A_BULK_SPACE ? {20'h0, free_space} :
		addr == cpf_pkg::A_HOLD ? {31'h0, hold_r} :
		addr == cpf_pkg::A_STATUS ? status :
		addr == cpf_pkg::A_GLYPH_Q ? q_metrics :
		addr == cpf_pkg::A_GLYPH_ADDR ? q_width_addr :
		addr == cpf_pkg::A_RADIUS ? {14'h0, radius} : 32'h0;

	// ==========================================================
	// Ring store and fetch read port
	always_ff @(posedge ref_clk)
	begin
		if (ring_we)
			ring_mem[ring_widx] <= wdata;
		ring_q_r <= ring_mem[fetch_ptr_r[11:2]];
	end

	// Host-owned registers and read data
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr_r <= 12'h000;
			hold_r <= 1'b0;
			q_handle_r <= 5'h00;
			q_code_r <= 8'h00;
			height_r <= 16'h0000;
			rdata_r <= 32'h0;
		end
		else
		begin
			rdata_r <= rd ? rd_mux : 32'h0;
			if (wr_wptr)
				wr_ptr_r <= wdata[11:0];
			else if (wr_bulk)
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			if (wr_hold)
				hold_r <= wdata[0];
			if (wr_query)
			begin
				q_handle_r <= wdata[12:8];
				q_code_r <= wdata[7:0];
			end
			if (wr_height)
				height_r <= wdata[15:0];
		end
	end

	// Engine sequencer: fetch, execute, commit read pointer
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= cpf_pkg::ST_IDLE;
			rd_ptr_r <= 12'h000;
			fetch_ptr_r <= 12'h000;
			op_r <= cpf_pkg::OPK_NONE;
			args_left_r <= 2'h0;
			arg0_r <= 32'h0;
			skip_r <= 30'h0;
			queue_drained_irq_r <= 1'b0;
		end
		else if (hold_r)
		begin
			state_r <= cpf_pkg::ST_IDLE;
			op_r <= cpf_pkg::OPK_NONE;
			args_left_r <= 2'h0;
			skip_r <= 30'h0;
			queue_drained_irq_r <= 1'b0;
			if (wr_rptr)
			begin
				rd_ptr_r <= wdata[11:0];
				fetch_ptr_r <= wdata[11:0];
			end
		end
		else if (fault_go)
		begin
			state_r <= cpf_pkg::ST_FAULT;
			rd_ptr_r <= cpf_pkg::PTR_FAULT;
			queue_drained_irq_r <= 1'b1;
		end
		else
		begin
			queue_drained_irq_r <= drain_go;
			case (state_r)
				cpf_pkg::ST_IDLE:
					if (fetch_ptr_r != wr_ptr_r)
						state_r <= cpf_pkg::ST_EXEC;
				cpf_pkg::ST_EXEC:
				begin
					state_r <= cpf_pkg::ST_IDLE;
					fetch_ptr_r <= fetch_nxt;
					if (cmd_done)
						rd_ptr_r <= fetch_nxt;
					if (in_skip)
						skip_r <= skip_r - 30'h1;
					else if (in_args)
					begin
						args_left_r <= args_left_r - 2'h1;
						if (args_left_r == 2'h2)
							arg0_r <= w;
						if (last_arg && op_r == cpf_pkg::OPK_INLINE)
							skip_r <= skip_len;
					end
					else if (is_co && (op_assign || op_bind))
					begin
						op_r <= op_assign ? cpf_pkg::OPK_ASSIGN : cpf_pkg::OPK_BIND;
						args_left_r <= 2'h2;
					end
					else if (is_co && op_inline)
					begin
						op_r <= cpf_pkg::OPK_INLINE;
						args_left_r <= 2'h1;
					end
				end
				cpf_pkg::ST_FAULT:
					state_r <= cpf_pkg::ST_FAULT;
				default:
					state_r <= cpf_pkg::ST_IDLE;
			endcase
		end
	end

	// Handle table: built-in defaults, assign and bind commands
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < cpf_pkg::HANDLES; i++)
			begin
				font_num_r[i] <= 6'(i);
				font_ok_r[i] <= i >= 16;
				cust_r[i] <= 1'b0;
				cust_addr_r[i] <= 32'h0;
			end
		end
		else if (last_arg && !bad_cmd && op_r == cpf_pkg::OPK_ASSIGN)
		begin
			font_num_r[arg_h] <= w[5:0];
			font_ok_r[arg_h] <= 1'b1;
			cust_r[arg_h] <= 1'b0;
		end
		else if (last_arg && op_r == cpf_pkg::OPK_BIND)
		begin
			cust_addr_r[arg_h] <= w;
			font_ok_r[arg_h] <= 1'b1;
			cust_r[arg_h] <= 1'b1;
		end
	end

	// Display list writer
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dl_cnt_r <= 12'h000;
			dl_we_r <= 1'b0;
			dl_addr_r <= 11'h000;
			dl_data_r <= 32'h0;
		end
		else
		begin
			dl_we_r <= copy_go;
			if (new_list_go)
				dl_cnt_r <= 12'h000;
			else if (copy_go)
			begin
				dl_addr_r <= dl_cnt_r[10:0];
				dl_data_r <= w;
				dl_cnt_r <= dl_cnt_r + 12'h001;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Hold keeps the faulted read pointer until the host rewrites it
	ptr_align_a: assert property (state_r != cpf_pkg::ST_FAULT && !hold_r
		|-> rd_ptr_r[1:0] == 2'h0)
		else $error("read pointer unaligned outside fault");
	fault_ptr_a: assert property (state_r == cpf_pkg::ST_FAULT |-> rd_ptr_r == cpf_pkg::PTR_FAULT)
		else $error("fault without illegal read pointer");
	fault_irq_a: assert property ($rose(state_r == cpf_pkg::ST_FAULT) |-> queue_drained_irq_r)
		else $error("fault entered without drained irq");
	copy_word_a: assert property (copy_go |=> dl_we_r && dl_data_r == $past(ring_q_r))
		else $error("list word not copied unchanged");
	list_step_a: assert property (dl_we_r |-> dl_cnt_r == {1'b0, dl_addr_r} + 12'h001)
		else $error("list offset did not follow write");
	new_list_a: assert property (new_list_go |=> dl_cnt_r == 12'h000 && !dl_we_r)
		else $error("new list did not clear offset");
	drain_ptr_a: assert property (drain_go && !fault_go |=> queue_drained_irq_r
		&& rd_ptr_r == $past(wr_ptr_r))
		else $error("drained irq without empty ring");
	commit_only_a: assert property (state_r == cpf_pkg::ST_IDLE && !in_args && !in_skip
		&& !hold_r |-> rd_ptr_r == fetch_ptr_r)
		else $error("read pointer not at command boundary");
	bulk_step_a: assert property (wr_bulk && !wr_wptr |=> wr_ptr_r == $past(wr_ptr_r) + 12'h004)
		else $error("bulk write did not advance pointer");
	skip_count_a: assert property (exec && in_skip && !bad_cmd |=> skip_r == $past(skip_r) - 30'h1)
		else $error("pad skip count wrong");

	// Sequencing: pulses last one cycle, hold parks the engine,
	// and the read pointer moves only at a command boundary
	irq_pulse_a: assert property (queue_drained_irq_r |=> !queue_drained_irq_r)
		else $error("drained irq longer than one cycle");
	dl_pulse_a: assert property (dl_we_r |=> !dl_we_r)
		else $error("list write longer than one cycle");
	hold_stop_a: assert property (hold_r |=> state_r == cpf_pkg::ST_IDLE && !dl_we_r)
		else $error("engine ran while held");
	rd_commit_a: assert property (!cmd_done && !hold_r && !fault_go |=> $stable(rd_ptr_r))
		else $error("read pointer moved without a finished command");
	bad_op_a: assert property (is_head && is_co && !op_known
		|=> state_r == cpf_pkg::ST_FAULT && queue_drained_irq_r)
		else $error("unknown command did not fault");
	unaligned_wp_a: assert property (bad_wptr && !hold_r && state_r != cpf_pkg::ST_FAULT
		|=> rd_ptr_r == cpf_pkg::PTR_FAULT)
		else $error("unaligned write pointer did not fault");
	wrap_step_a: assert property (wr_bulk && wr_ptr_r == 12'hFFC |=> wr_ptr_r == 12'h000)
		else $error("bulk write did not wrap");

	// Main scenarios; all but cov_bulk_c are reached by the bench
	cov_fault_c: cover property ($rose(state_r == cpf_pkg::ST_FAULT));
	cov_drain_c: cover property (queue_drained_irq_r && state_r == cpf_pkg::ST_IDLE);
	cov_inline_c: cover property (exec && skip_r == 30'h1);
	cov_bulk_c: cover property (wr_bulk ##1 wr_bulk);
	cov_hold_c: cover property (hold_r ##1 !hold_r);
endmodule

`default_nettype wire

// ### hw/cpf_pkg.sv
// Purpose: Shared constants and types of the command ring front end
// Assumes: 32-bit register port with byte addresses, ring window at 0x0000
// Notes: Host side reuses the map and the command codes from here
package cpf_pkg;
	// ==========================================================
	// Ring and pointers
	localparam int PTR_W = 12;
	localparam int ADDR_W = 13;
	localparam int RING_WORDS = 1024;
	localparam logic [11:0] PTR_STEP = 12'h004;
	localparam logic [11:0] RING_USABLE = 12'hFFC;
	localparam logic [11:0] PTR_FAULT = 12'hFFF;
	// ==========================================================
	// Register map, byte addresses
	localparam logic [12:0] A_RING_TOP = 13'h1000;
	localparam logic [12:0] A_RD_PTR = 13'h1000;
	localparam logic [12:0] A_WR_PTR = 13'h1004;
	localparam logic [12:0] A_LIST_OFS = 13'h1008;
	localparam logic [12:0] A_BULK_SPACE = 13'h100C;
	localparam logic [12:0] A_BULK_WR = 13'h1010;
	localparam logic [12:0] A_HOLD = 13'h1014;
	localparam logic [12:0] A_STATUS = 13'h1018;
	localparam logic [12:0] A_GLYPH_Q = 13'h101C;
	localparam logic [12:0] A_GLYPH_ADDR = 13'h1020;
	localparam logic [12:0] A_RADIUS = 13'h1024;
	localparam int STAT_IDLE = 0;
	localparam int STAT_FAULT = 1;
	localparam int STAT_HOLD = 2;
	localparam int STAT_VALID = 3;
	// ==========================================================
	// Command words
	localparam logic [7:0] OP_COPROC = 8'hFF;
	localparam logic [23:0] OP_NEW_LIST = 24'h000000;
	localparam logic [23:0] OP_ASSIGN_BI = 24'h000001;
	localparam logic [23:0] OP_BIND_CUST = 24'h000002;
	localparam logic [23:0] OP_INLINE = 24'h000003;
	localparam int DL_W = 11;
	// ==========================================================
	// Fonts and metrics blocks
	localparam int HANDLES = 32;
	localparam logic [31:0] METRICS_BYTES = 32'h00000094;
	localparam logic [7:0] MET_FORMAT = 8'h80;
	localparam logic [7:0] MET_STRIDE = 8'h84;
	localparam logic [7:0] MET_WIDTH = 8'h88;
	localparam logic [7:0] MET_HEIGHT = 8'h8C;
	localparam logic [7:0] MET_DATA = 8'h90;
	localparam logic [31:0] ROOT_PTR_ADDR = 32'h002FFFFC;
	localparam logic [31:0] BUILTIN_BASE = 32'h00201EE0;
	localparam logic [5:0] FONT_FIRST = 6'h10;
	localparam logic [5:0] FONT_LAST = 6'h22;
	localparam logic [5:0] FONT_HI_A = 6'h11;
	localparam logic [5:0] FONT_HI_B = 6'h13;
	localparam logic [7:0] CHAR_LO = 8'h20;
	localparam logic [7:0] CHAR_HI = 8'h7E;
	localparam logic [7:0] CHAR_SHIFT = 8'h80;
	localparam logic [1:0] RADIUS_MUL = 2'h3;
	localparam int RADIUS_SHIFT = 4;
	// ==========================================================
	// Engine states and pending command kinds
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_FAULT = 3'b100} cpf_state_t;
	typedef enum logic [1:0] {OPK_NONE = 2'h0, OPK_ASSIGN = 2'h1, OPK_BIND = 2'h2,
		OPK_INLINE = 2'h3} cpf_op_t;
endpackage

// ### test/cpf_frontend_tb.sv
// Purpose: Self-checking bench for the command ring front end
// Assumes: Host model drives the register port
// Notes: Display list writes and drain pulses are logged by monitors
`timescale 1ns/100ps
`default_nettype none
module cpf_frontend_tb;
	logic ref_clk;
	logic rstn;
	logic [12:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata_r;
	logic dl_we_r;
	logic [10:0] dl_addr_r;
	logic [31:0] dl_data_r;
	logic queue_drained_irq_r;
	int num_errors = 0;
	int tests_run = 0;
	int irq_n = 0;
	logic [10:0] dl_a_q[$];
	logic [31:0] dl_d_q[$];
	localparam logic [31:0] B = cpf_pkg::BUILTIN_BASE;
	localparam logic [31:0] M = cpf_pkg::METRICS_BYTES;
	localparam logic [4:0] GH [8] = '{5'h10, 5'h14, 5'h1F, 5'h11, 5'h11, 5'h05, 5'h03, 5'h00};
	localparam logic [7:0] GC [8] = '{8'h41, 8'h20, 8'h7E, 8'h41, 8'h81, 8'h67, 8'h10, 8'h41};
	localparam logic GV [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam logic [31:0] GB [8] = '{B, B + 32'h4 * M, B + 32'hF * M, B + M, B + M,
		B + 32'h12 * M, 32'h00001000, 32'h00000000};
	localparam logic [15:0] RH [3] = '{16'h0020, 16'h0015, 16'hFFFF};
	localparam logic [31:0] RR [3] = '{32'h00000006, 32'h00000003, 32'h00002FFF};
	// ==========================================================
	// Design, host model, clock and monitors
	cpf_frontend u_cpf_frontend (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_r(rdata_r), .dl_we_r(dl_we_r), .dl_addr_r(dl_addr_r),
		.dl_data_r(dl_data_r), .queue_drained_irq_r(queue_drained_irq_r));
	cpf_host_model u_cpf_host_model (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_r(rdata_r));
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Log every list write and drain pulse
	always @(posedge ref_clk)
	begin
		if (dl_we_r === 1'b1)
		begin
			dl_a_q.push_back(dl_addr_r);
			dl_d_q.push_back(dl_data_r);
		end
		if (queue_drained_irq_r === 1'b1)
			irq_n++;
	end
	// ==========================================================
	// Helpers
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic rr(input logic [12:0] a, output logic [31:0] d);
		u_cpf_host_model.reg_rd(a, d);
	endtask
	task automatic ww(input logic [12:0] a, input logic [31:0] d);
		u_cpf_host_model.reg_wr(a, d);
	endtask
	task automatic push(input logic [31:0] w);
		u_cpf_host_model.push(w);
	endtask
	// Bounded poll until the engine reports idle
	task automatic wait_idle();
		logic [31:0] s;
		int i;
		s = 32'h00000000;
		for (i = 0; i < 100 && s[cpf_pkg::STAT_IDLE] !== 1'b1; i++)
			rr(cpf_pkg::A_STATUS, s);
		if (s[cpf_pkg::STAT_IDLE] !== 1'b1)
		begin
			check(s, 32'h00000001);
			stop_test();
		end
	endtask
	// Pop the oldest list write and compare it
	task automatic chk_dl(input logic [10:0] a, input logic [31:0] d);
		check({31'h0, dl_d_q.size() != 0}, 32'h00000001);
		if (dl_d_q.size() != 0)
		begin
			check({21'h0, dl_a_q.pop_front()}, {21'h0, a});
			check(dl_d_q.pop_front(), d);
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		localparam logic [12:0] RA [6] = '{cpf_pkg::A_RD_PTR, cpf_pkg::A_WR_PTR,
			cpf_pkg::A_LIST_OFS, cpf_pkg::A_BULK_SPACE, cpf_pkg::A_HOLD, 13'h1FFC};
		localparam logic [31:0] RE [6] = '{32'h0, 32'h0, 32'h0, 32'hFFC, 32'h0, 32'h0};
		logic [31:0] s;
		int i;
		for (i = 0; i < 6; i++)
		begin
			rr(RA[i], s);
			check(s, RE[i]);
		end
		rr(cpf_pkg::A_STATUS, s);
		check(s & 32'h7, 32'h00000001);
	endtask
	// Single plain word: copied, pointer moves, drain pulse
	task automatic t_plain();
		logic [31:0] s;
		int n0;
		n0 = irq_n;
		push(32'h12345678);
		wait_idle();
		chk_dl(11'h000, 32'h12345678);
		rr(cpf_pkg::A_RD_PTR, s);
		check(s, 32'h00000004);
		check(irq_n - n0, 32'h00000001);
		rr(cpf_pkg::A_LIST_OFS, s);
		check(s, 32'h00000004);
	endtask
	// New list, inline data with pad bytes, then a plain word
	task automatic t_newlist();
		logic [31:0] s;
		push({cpf_pkg::OP_COPROC, cpf_pkg::OP_NEW_LIST});
		push({cpf_pkg::OP_COPROC, cpf_pkg::OP_INLINE});
		push(32'h00000005);
		push(32'h11111111);
		push(32'h22222222);
		push(32'hAABBCCDD);
		wait_idle();
		chk_dl(11'h000, 32'hAABBCCDD);
		check(dl_d_q.size(), 32'h00000000);
		rr(cpf_pkg::A_LIST_OFS, s);
		check(s, 32'h00000004);
	endtask
	// Bulk writes across the top of the ring
	task automatic t_wrap();
		logic [31:0] s;
		u_cpf_host_model.set_ptrs(12'hFFC);
		u_cpf_host_model.bulk(32'h0A0A0A0A);
		u_cpf_host_model.bulk(32'h0B0B0B0B);
		wait_idle();
		chk_dl(11'h001, 32'h0A0A0A0A);
		chk_dl(11'h002, 32'h0B0B0B0B);
		rr(cpf_pkg::A_WR_PTR, s);
		check(s, 32'h00000004);
		rr(cpf_pkg::A_BULK_SPACE, s);
		check(s, u_cpf_host_model.free_space(12'h004, 12'h004));
	endtask
	// Unaligned write pointer faults; then recovery
	task automatic t_fault();
		logic [31:0] s;
		int n0;
		n0 = irq_n;
		ww(cpf_pkg::A_WR_PTR, 32'h00000006);
		rr(cpf_pkg::A_RD_PTR, s);
		check(s, {20'h0, cpf_pkg::PTR_FAULT});
		rr(cpf_pkg::A_STATUS, s);
		check(s & 32'h3, 32'h00000002);
		rr(cpf_pkg::A_BULK_SPACE, s);
		check(s, 32'h00000000);
		check(irq_n - n0, 32'h00000001);
		u_cpf_host_model.set_ptrs(12'h000);
		rr(cpf_pkg::A_RD_PTR, s);
		check(s, 32'h00000000);
		rr(cpf_pkg::A_STATUS, s);
		check(s & 32'h7, 32'h00000001);
		push({cpf_pkg::OP_COPROC, 24'h0000AB});
		repeat (4) @(posedge ref_clk);
		rr(cpf_pkg::A_RD_PTR, s);
		check(s, {20'h0, cpf_pkg::PTR_FAULT});
		check(irq_n - n0, 32'h00000002);
		u_cpf_host_model.set_ptrs(12'h000);
		rr(cpf_pkg::A_STATUS, s);
		check(s & 32'h7, 32'h00000001);
	endtask
	// Font binding, metrics lookup and corner radius
	task automatic t_glyph();
		logic [31:0] s;
		int i;
		push({cpf_pkg::OP_COPROC, cpf_pkg::OP_ASSIGN_BI});
		push(32'h00000005);
		push(32'h00000022);
		push({cpf_pkg::OP_COPROC, cpf_pkg::OP_BIND_CUST});
		push(32'h00000003);
		push(32'h00001000);
		wait_idle();
		for (i = 0; i < 8; i++)
		begin
			ww(cpf_pkg::A_GLYPH_Q, {19'h0, GH[i], GC[i]});
			rr(cpf_pkg::A_STATUS, s);
			check({31'h0, s[cpf_pkg::STAT_VALID]}, {31'h0, GV[i]});
			if (GV[i])
			begin
				rr(cpf_pkg::A_GLYPH_Q, s);
				check(s, GB[i]);
				rr(cpf_pkg::A_GLYPH_ADDR, s);
				if (GH[i] != 5'h11)
					check(s, GB[i] + {24'h0, GC[i]});
				else
					check(s, GB[i] + {24'h0, GC[i] - cpf_pkg::CHAR_SHIFT});
			end
		end
		for (i = 0; i < 3; i++)
		begin
			ww(cpf_pkg::A_RADIUS, {16'h0, RH[i]});
			rr(cpf_pkg::A_RADIUS, s);
			check(s, RR[i]);
		end
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		rstn = 1'b0;
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset();
		t_plain();
		t_newlist();
		t_wrap();
		t_fault();
		t_glyph();
		stop_test();
	end
endmodule
`default_nettype wire

// ### test/cpf_host_model.sv
// Purpose: Host side model that drives the register port of the command ring front end
// Assumes: Strobes last one cycle and read data stand in the cycle after the strobe
// Notes: Keeps its own copy of the write pointer
`timescale 1ns/100ps
`default_nettype none
module cpf_host_model (
	input wire logic ref_clk,
	output var logic [12:0] addr,
	output var logic [31:0] wdata,
	output var logic wr,
	output var logic rd,
	input wire logic [31:0] rdata_r
);
	logic [11:0] wptr;
	// ==========================================================
	// Bus idle at time zero
	initial
	begin
		addr = 13'h0000;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		wptr = 12'h000;
	end
	// One write cycle; data inverted once released so stale values do not linger
	task automatic reg_wr(input logic [12:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// One read cycle; data taken in the cycle after the strobe
	task automatic reg_rd(input logic [12:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata_r;
	endtask
	// Deposit one word, then advance the write pointer
	task automatic push(input logic [31:0] w);
		reg_wr({1'b0, wptr}, w);
		wptr = wptr + cpf_pkg::PTR_STEP;
		reg_wr(cpf_pkg::A_WR_PTR, {20'h00000, wptr});
	endtask
	// Bulk port write; the front end moves the pointer, the copy follows
	task automatic bulk(input logic [31:0] w);
		reg_wr(cpf_pkg::A_BULK_WR, w);
		wptr = wptr + cpf_pkg::PTR_STEP;
	endtask
	// Hold engine, set both pointers, release
	task automatic set_ptrs(input logic [11:0] p);
		reg_wr(cpf_pkg::A_HOLD, 32'h00000001);
		reg_wr(cpf_pkg::A_RD_PTR, {20'h00000, p});
		reg_wr(cpf_pkg::A_WR_PTR, {20'h00000, p});
		reg_wr(cpf_pkg::A_HOLD, 32'h00000000);
		wptr = p;
	endtask
	// Free space as the host reckons it
	function automatic logic [31:0] free_space(input logic [11:0] w, input logic [11:0] r);
		return {20'h00000, cpf_pkg::RING_USABLE - (w - r)};
	endfunction
endmodule
`default_nettype wire
